/* File: hw/hbp_if.sv */
// Pin-level carrier between the host processor and the device port.
`timescale 1ns/1ps
`default_nettype none
interface hbp_if;
	logic read_strobe_n;
	logic write_strobe_n;
	logic chip_select_n;
	logic ale;
	logic [9:0] host_address_pins;
	logic [7:0] host_data_host_o;
	logic host_data_host_oe;
	logic [7:0] host_data_dev_o;
	logic host_data_dev_oe;
	logic bus_ready_n;
	// Resolved level seen on the shared data pins.
	logic [7:0] host_data_pins;
	assign host_data_pins = host_data_dev_oe ? host_data_dev_o :
		(host_data_host_oe ? host_data_host_o : 8'hFF);
	modport dev (input read_strobe_n, input write_strobe_n, input chip_select_n, input ale,
		input host_address_pins, input host_data_pins, output host_data_dev_o,
		output host_data_dev_oe, output bus_ready_n);
	modport host (output read_strobe_n, output write_strobe_n, output chip_select_n,
		output ale, output host_address_pins, output host_data_host_o,
		output host_data_host_oe, input host_data_pins, input bus_ready_n);
endinterface
`default_nettype wire

/* File: hw/hbp_pkg.sv */
// Shared constants for the host bus port and its host end.
package hbp_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 10;
	// Host configuration codes on the two mode inputs.
	localparam logic [1:0] CFG_SYNC_MUX = 2'h1;
	localparam logic [1:0] CFG_ASYNC = 2'h0;
	// Fixed upper address bits for the internal decoder in synchronous mode.
	localparam logic [7:0] SYNC_WIN_HI = 8'h00;
	localparam int SYNC_WIN_LSB = 2;
	// Clock rate and write settle time in device clock edges.
	localparam int CLK_MHZ = 40;
	localparam int WR_SETTLE_EDGES = 4;
	localparam logic [2:0] WR_SETTLE_CYC = 3'(WR_SETTLE_EDGES);
	// Reset values.
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [9:0] ADDR_RST = 10'h000;
	localparam logic [2:0] CNT_RST = 3'h0;
	// Idle level of the three synchronised select and strobe pins.
	localparam logic [2:0] PIN_IDLE = 3'h7;
endpackage

/* File: hw/host_bus_master.sv */
// Host end: drives strobes, address and data, waits on ready in async mode.
`timescale 1ns/1ps
`default_nettype none
module host_bus_master (
	input wire logic mclk,
	input wire logic rst,
	input wire logic async_mode,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [hbp_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [hbp_pkg::DATA_W-1:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [hbp_pkg::DATA_W-1:0] rsp_rdata,
	hbp_if.host bus
);
	import hbp_pkg::*;

	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_ALE = 5'b00010,
		H_STRB = 5'b00100,
		H_END = 5'b01000,
		H_GAP = 5'b10000
	} hst_t;

	typedef struct packed {
		hst_t st;
		logic [1:0] rdy_s;
		logic we;
		logic [9:0] addr;
		logic [7:0] wd;
		logic [7:0] rd;
		logic rv;
		logic [2:0] cnt;
	} hstate_t;

	hstate_t h_r;
	hstate_t h_nxt;

	// Sequencer: address phase, strobe, wait, release, write spacing.
	always_comb begin
		h_nxt = h_r;
		h_nxt.rdy_s = {h_r.rdy_s[0], ~bus.bus_ready_n};
		h_nxt.rv = 1'b0;
		case (h_r.st)
			H_IDLE: begin
				if (cmd_valid) begin
					h_nxt.we = cmd_write;
					h_nxt.addr = cmd_addr;
					h_nxt.wd = cmd_wdata;
					h_nxt.st = async_mode ? H_STRB : H_ALE;
					h_nxt.cnt = WR_SETTLE_CYC;
				end
			end
			H_ALE: h_nxt.st = H_STRB;
			H_STRB: begin
				// Async waits on ready; sync uses fixed strobe length.
				if (async_mode ? h_r.rdy_s[1] : (h_r.cnt == CNT_RST)) begin
					h_nxt.rd = bus.host_data_pins;
					h_nxt.st = H_END;
				end else if (h_r.cnt != CNT_RST) begin
					h_nxt.cnt = h_r.cnt - 3'h1;
				end
			end
			H_END: begin
				h_nxt.rv = !h_r.we;
				h_nxt.cnt = WR_SETTLE_CYC;
				h_nxt.st = H_GAP;
			end
			H_GAP: begin
				// Keep at least four clocks between accesses.
				if (h_r.cnt == CNT_RST) begin
					h_nxt.st = H_IDLE;
				end else begin
					h_nxt.cnt = h_r.cnt - 3'h1;
				end
			end
			default: h_nxt.st = H_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			h_r <= '{st: H_IDLE, rdy_s: 2'h0, we: 1'b0, addr: ADDR_RST, wd: DATA_RST,
				rd: DATA_RST, rv: 1'b0, cnt: CNT_RST};
		end else begin
			h_r <= h_nxt;
		end
	end

	// Pin drive; the low address byte rides on the data pins in sync mode.
	assign bus.chip_select_n = !(async_mode && (h_r.st == H_STRB));
	assign bus.ale = !async_mode && (h_r.st == H_ALE);
	assign bus.read_strobe_n = !((h_r.st == H_STRB) && !h_r.we);
	assign bus.write_strobe_n = !((h_r.st == H_STRB) && h_r.we);
	assign bus.host_address_pins = h_r.addr;
	assign bus.host_data_host_o = (h_r.st == H_ALE) ? h_r.addr[7:0] : h_r.wd;
	assign bus.host_data_host_oe = (h_r.st == H_ALE) || ((h_r.st == H_STRB) && h_r.we);
	assign cmd_ready = (h_r.st == H_IDLE);
	assign rsp_valid = h_r.rv;
	assign rsp_rdata = h_r.rd;
endmodule
`default_nettype wire

/* File: hw/host_bus_sync_async_port.sv */
// Device end of the host bus: strobe capture, decode, ready and RAM requests.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Sync mode: access starts on strobe falling edge.
// - Host sets async select bit before async use.
// - Async mode: access starts on strobe falling edge.
// - Async mode ignores the address latch strobe.
// - Async mode uses only external chip select.
// - Async: host side does address decode and select.
// - Async bus: 8-bit data, 10-bit address.
// - Ready ends async access; host waits on it.
// - Word hosts swap bytes or use low byte.
// - Sync: latch low address, decode zero window.
// - Writes settle four clocks; host spaces them.
// - Config (0,1) sync, (0,0) async.
module host_bus_sync_async_port (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [1:0] host_cfg,
	input wire logic async_host_select_bit,
	hbp_if.dev bus,
	output logic ram_req,
	output logic ram_we,
	output logic [hbp_pkg::ADDR_W-1:0] ram_addr,
	output logic [hbp_pkg::DATA_W-1:0] ram_wdata,
	input wire logic [hbp_pkg::DATA_W-1:0] ram_rdata,
	input wire logic ram_ack,
	output logic wr_busy,
	output logic cfg_error
);
	import hbp_pkg::*;

	////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_DONE = 3'b100
	} st_t;

	typedef struct packed {
		logic [2:0] rd_s1;
		logic [2:0] rd_s2;
		logic [9:0] a_s1;
		logic [9:0] a_s2;
		logic [7:0] d_s1;
		logic [7:0] d_s2;
		logic ale_s1;
		logic ale_s2;
		logic [7:0] alat;
		logic strb_prev;
		st_t st;
		logic we;
		logic req;
		logic [9:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic rdy;
		logic oe;
		logic [2:0] wcnt;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	////////////////////////////////////////////////////////////////
	// Internal chip select for the fixed synchronous window.
	function automatic logic sync_hit(input logic [9:0] a);
		return a[9:SYNC_WIN_LSB] == SYNC_WIN_HI;
	endfunction

	// The asynchronous code on the mode inputs, used by the decode and the error flag.
	function automatic logic async_code(input logic [1:0] cfg);
		return cfg == CFG_ASYNC;
	endfunction

	logic async_mode;
	logic sync_mode;
	logic rd_a;
	logic wr_a;
	logic cs_a;
	logic ale_a;
	logic [9:0] eff_addr;
	logic sel;
	logic strb;

	////////////////////////////////////////////////////////////////
	// Mode decode and qualified select from synchronised pin levels.
	always_comb begin
		async_mode = async_code(host_cfg) && async_host_select_bit;
		sync_mode = (host_cfg == CFG_SYNC_MUX);
		rd_a = ~s_r.rd_s2[0];
		wr_a = ~s_r.rd_s2[1];
		cs_a = ~s_r.rd_s2[2];
		ale_a = s_r.ale_s2;
		eff_addr = async_mode ? s_r.a_s2 : {s_r.a_s2[9:8], s_r.alat};
		sel = async_mode ? cs_a : (sync_mode && sync_hit(eff_addr));
		strb = rd_a | wr_a;
	end

	////////////////////////////////////////////////////////////////
	// Next-state logic for the whole port.
	always_comb begin
		s_nxt = s_r;
		// Every pin passes two flip-flops; the latch strobe is delayed like the data.
		s_nxt.rd_s1 = {bus.chip_select_n, bus.write_strobe_n, bus.read_strobe_n};
		s_nxt.rd_s2 = s_r.rd_s1;
		s_nxt.a_s1 = bus.host_address_pins;
		s_nxt.a_s2 = s_r.a_s1;
		s_nxt.d_s1 = bus.host_data_pins;
		s_nxt.d_s2 = s_r.d_s1;
		s_nxt.ale_s1 = bus.ale;
		s_nxt.ale_s2 = s_r.ale_s1;
		s_nxt.strb_prev = strb;
		s_nxt.req = 1'b0;
		// Address latch is loaded while the strobe is high, only in sync mode.
		// In async mode the latch strobe is masked, whatever level it shows.
		if (sync_mode && ale_a) begin
			s_nxt.alat = s_r.d_s2;
		end
		// The settle counter runs down after every write.
		if (s_r.wcnt != CNT_RST) begin
			s_nxt.wcnt = s_r.wcnt - 3'h1;
		end
		// Access sequencer: idle, waiting on the RAM, done until release.
		case (s_r.st)
			ST_IDLE: begin
				// Falling edge of either strobe opens an access.
				if (strb && !s_r.strb_prev && sel) begin
					s_nxt.st = ST_WAIT;
					s_nxt.req = 1'b1;
					s_nxt.we = wr_a;
					s_nxt.addr = eff_addr;
					s_nxt.wdata = s_r.d_s2;
				end
			end
			ST_WAIT: begin
				if (ram_ack) begin
					s_nxt.st = ST_DONE;
					s_nxt.rdata = ram_rdata;
					s_nxt.rdy = async_mode;
					if (s_r.we) begin
						s_nxt.wcnt = WR_SETTLE_CYC;
					end
				end else begin
					s_nxt.req = 1'b1;
				end
			end
			ST_DONE: begin
				if (!strb || !sel) begin
					s_nxt.rdy = 1'b0;
					s_nxt.st = ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		// Data pins are driven only while selected and reading.
		// Opening the drive with the done state lets a fixed-length strobe see the data.
		s_nxt.oe = sel && rd_a && (s_nxt.st == ST_DONE) && !s_nxt.we;
		if (!strb || !sel) begin
			s_nxt.rdy = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_r <= '{
				rd_s1: PIN_IDLE,
				rd_s2: PIN_IDLE,
				a_s1: ADDR_RST,
				a_s2: ADDR_RST,
				d_s1: DATA_RST,
				d_s2: DATA_RST,
				ale_s1: 1'b0,
				ale_s2: 1'b0,
				alat: DATA_RST,
				strb_prev: 1'b0,
				st: ST_IDLE,
				we: 1'b0,
				req: 1'b0,
				addr: ADDR_RST,
				wdata: DATA_RST,
				rdata: DATA_RST,
				rdy: 1'b0,
				oe: 1'b0,
				wcnt: CNT_RST
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs toward the pins and the RAM controller.
	assign bus.host_data_dev_o = s_r.rdata;
	assign bus.host_data_dev_oe = s_r.oe;
	assign bus.bus_ready_n = ~s_r.rdy;
	assign ram_req = s_r.req;
	assign ram_we = s_r.we;
	assign ram_addr = s_r.addr;
	assign ram_wdata = s_r.wdata;
	assign wr_busy = (s_r.wcnt != CNT_RST);
	assign cfg_error = async_code(host_cfg) && !async_host_select_bit;
endmodule
`default_nettype wire

/* File: verification/hbp_checker.sv */
// Interface assertions for the host bus port pair.
`timescale 1ns/1ps
`default_nettype none
module hbp_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic async_mode,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chip_select_n,
	input wire logic host_data_host_oe,
	input wire logic host_data_dev_oe,
	input wire logic bus_ready_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// High while neither strobe is active.
	wire logic idle = read_strobe_n & write_strobe_n;
	////////////////////////////////////////////////////////////////
	// Data pin ownership, the ready handshake and write spacing.
	a_oe_release: assert property ($rose(read_strobe_n) |-> ##[0:4] !host_data_dev_oe)
		else $error("data pins still driven after read");
	a_no_contention: assert property (!(host_data_dev_oe && host_data_host_oe))
		else $error("both ends drive the data pins");
	a_ready_release: assert property ($rose(idle) |-> ##[0:4] bus_ready_n)
		else $error("ready held after strobe release");
	a_ready_cause: assert property ($fell(bus_ready_n) |-> async_mode && !chip_select_n && !idle)
		else $error("ready without selected access");
	a_ready_not_early: assert property ($fell(idle) |-> bus_ready_n [*4])
		else $error("ready before request could be served");
	a_ready_bounded: assert property (async_mode && $fell(idle) |-> ##[1:40] !bus_ready_n)
		else $error("async access never completed");
	a_sync_no_ready: assert property (!async_mode |-> bus_ready_n)
		else $error("ready driven in synchronous mode");
	a_write_gap: assert property ($rose(write_strobe_n) |-> idle [*4])
		else $error("accesses closer than four clocks");
endmodule
`default_nettype wire

/* File: verification/host_bus_sync_async_port_test.sv */
// Testbench joining host end and device end of the host bus.
`timescale 1ns/1ps
`default_nettype none
module host_bus_sync_async_port_test;
	import hbp_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] host_cfg = CFG_ASYNC;
	logic sel_bit = 1'b1;
	logic async_mode = 1'b1;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [9:0] cmd_addr = 10'h000;
	logic [7:0] cmd_wdata = 8'h00;
	logic [7:0] ram_rdata = 8'h00;
	logic ram_ack = 1'b0;
	logic acked = 1'b0;
	logic cmd_ready, rsp_valid, ram_req, ram_we, wr_busy, cfg_error;
	logic [7:0] rsp_rdata, ram_wdata, rd, n0;
	logic [7:0] nreq = 8'h00;
	logic [9:0] ram_addr;
	logic [7:0] mem [1024];
	logic [9:0] adr [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
	logic [7:0] dat [4] = '{8'h5A, 8'hC3, 8'h01, 8'hFE};
	int fails = 0;
	int samples_checked = 0;
	int busy_cyc = 0;
	always #12.5 mclk = ~mclk;
	hbp_if bus_if ();
	host_bus_master u_host_bus_master (.mclk(mclk), .rst(rst), .async_mode(async_mode),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .bus(bus_if.host));
	host_bus_sync_async_port u_host_bus_sync_async_port (.mclk(mclk), .rst(rst),
		.host_cfg(host_cfg), .async_host_select_bit(sel_bit), .bus(bus_if.dev),
		.ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_rdata(ram_rdata), .ram_ack(ram_ack), .wr_busy(wr_busy), .cfg_error(cfg_error));
	hbp_checker chk (.mclk(mclk), .rst(rst), .async_mode(async_mode),
		.read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
		.chip_select_n(bus_if.chip_select_n), .host_data_host_oe(bus_if.host_data_host_oe),
		.host_data_dev_oe(bus_if.host_data_dev_oe), .bus_ready_n(bus_if.bus_ready_n));
	// RAM controller stand-in: one acknowledge per request, on the falling edge after it.
	always @(negedge mclk) begin
		ram_ack = 1'b0;
		if (wr_busy === 1'b1) begin
			busy_cyc++;
		end
		if (!ram_req) begin
			acked = 1'b0;
		end else if (!acked) begin
			acked = 1'b1;
			ram_ack = 1'b1;
			nreq = nreq + 8'h01;
			ram_rdata = mem[ram_addr];
			if (ram_we) begin
				mem[ram_addr] = ram_wdata;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Comparison, closing report and bus access tasks.
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One falling edge, with a bound on how long a wait may run.
	task automatic step(inout int n);
		@(negedge mclk);
		n++;
		if (n > 300) begin
			fails++;
			$display("CHECK FAILED at %0t: wait timed out", $time);
			end_of_test();
		end
	endtask
	// Issues one command and, for reads, captures the returned byte in rd.
	task automatic access(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1) step(n);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		step(n);
		cmd_valid = 1'b0;
		while (!w && rsp_valid !== 1'b1) step(n);
		rd = rsp_rdata;
		while (cmd_ready !== 1'b1 || ram_req !== 1'b0) step(n);
		repeat (8) @(negedge mclk);
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence: async writes and reads, mode error, sync window.
	initial begin
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		check8({7'h00, cfg_error}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			access(1'b1, adr[i], dat[i]);
			check8(mem[adr[i]], dat[i]);
		end
		for (int i = 0; i < 4; i++) begin
			access(1'b0, adr[i], 8'h00);
			check8(rd, dat[i]);
		end
		sel_bit = 1'b0;
		@(negedge mclk);
		check8({7'h00, cfg_error}, 8'h01);
		rst = 1'b1;
		host_cfg = CFG_SYNC_MUX;
		async_mode = 1'b0;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		access(1'b1, 10'h002, 8'h3C);
		check8(mem[10'h002], 8'h3C);
		access(1'b0, 10'h002, 8'h00);
		check8(rd, 8'h3C);
		n0 = nreq;
		access(1'b1, 10'h010, 8'h99);
		access(1'b0, 10'h011, 8'h00);
		check8(nreq, n0);
		check8(rd, 8'hFF);
		check8(8'(busy_cyc), 8'(5 * WR_SETTLE_EDGES));
		end_of_test();
	end
endmodule
`default_nettype wire
